// *** src/dsphp_pkg.sv ***
// Purpose: Shared constants and types for the dual style parallel host port
// Assumes: Byte wide host bus, 20 MHz core clock
// Notes: Status bit positions follow the handshake status byte layout
package dsphp_pkg;
  localparam logic [1:0] ADDR_MSG = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_LIN = 2'h2;
  localparam logic [1:0] ADDR_COD = 2'h3;
  localparam int BIT_OUT_VALID = 1;
  localparam int BIT_IN_PEND = 2;
  localparam int BIT_FULL_COD = 3;
  localparam int BIT_FULL_LIN = 4;
  localparam int BIT_RST_LIN = 5;
  localparam int BIT_RST_COD = 6;
  localparam logic [7:0] MSG_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
  localparam logic [5:0] ALMOST_FULL = 6'h1c;

  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] data;
  } dsphp_req_t;

  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] st_a_s;
    logic [1:0] st_b_s;
    logic [1:0] dir_s;
    logic [1:0] a_s0;
    logic [1:0] a_s1;
    logic [7:0] d_s0;
    logic [7:0] d_s1;
    logic active;
    logic rd_cyc;
    dsphp_req_t req;
    logic [7:0] msg_in;
    logic [7:0] msg_out;
    logic in_pend;
    logic out_valid;
    logic rst_lin;
    logic rst_cod;
    logic [7:0] dout;
    logic doe;
    logic irq_n;
    logic lin_push;
    logic cod_push;
    logic [7:0] push_data;
  } dsphp_state_t;
endpackage

// *** src/dsphp_fifo.sv ***
// Purpose: Parameterised flip-flop FIFO for audio input bytes
// Assumes: Single clock, synchronous clear
// Notes: Count output feeds the almost-full flag
`timescale 1ns/1ps
module dsphp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(D):0] level
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dsphp_fst_t;
  dsphp_fst_t st_r, st_nxt;
  logic [W-1:0] mem_r [D];
  logic push, pop;

  assign in_ready = (st_r.cnt != D[AW:0]);
  assign out_valid = (st_r.cnt != '0);
  assign out_data = mem_r[st_r.rp];
  assign level = st_r.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_nxt = st_r;
    if (push) st_nxt.wp = st_r.wp + 1'b1;
    if (pop) st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (rst) st_r <= '0;
    else st_r <= st_nxt;
    if (push) mem_r[st_r.wp] <= in_data;
  end
endmodule

// *** src/dsphp_port.sv ***
// Purpose: Dual style byte wide parallel host port of an audio DSP
// Assumes: Host pins asynchronous to SYS_CLK, cycles last several clocks
// Notes: Write data is sampled through synchronisers at cycle end, the address at cycle start
//
// Functional notes
// - Address pins pick message, status, linear audio or coded audio register.
// - Only message and status bytes read back; audio addresses return nothing.
// - Write ends when strobes rise; device takes the byte then.
// - Separate-strobe read: chip select and fetch strobe low, device drives data.
// - Read ends when strobes rise; device releases the data pins.
// - Single-strobe read starts with chip select and strobe A low, strobe B high; device presents register value.
// - Pending output low while an outgoing message waits and notification enabled.
// - Status outbound-valid bit mirrors the outgoing-message flag; unlike the pending output, notification enable does not gate it.
// - Host message write sets inbound-pending; DSP consume clears it.
// - DSP message write sets outbound-valid; host message read clears it.
// - Audio address writes push into the matching input FIFO.
`timescale 1ns/1ps
module dsphp_port (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic SINGLE_STROBE_MODE,
  input wire logic CHIP_SEL_N,
  input wire logic STROBE_A_N,
  input wire logic STROBE_B_N,
  input wire logic REG_SEL_HI,
  input wire logic REG_SEL_LO,
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  output logic MESSAGE_PENDING_N,
  input wire logic NOTIFY_EN,
  input wire logic DSP_MSG_WR,
  input wire logic [7:0] DSP_MSG_WDATA,
  input wire logic DSP_MSG_RD,
  output logic [7:0] DSP_MSG_RDATA,
  output logic DSP_IN_PEND,
  output logic DSP_OUT_VALID,
  output logic [7:0] LIN_DATA,
  output logic LIN_VALID,
  input wire logic LIN_READY,
  output logic [7:0] COD_DATA,
  output logic COD_VALID,
  input wire logic COD_READY,
  output logic LIN_PORT_RST,
  output logic COD_PORT_RST
);
  dsphp_pkg::dsphp_state_t st_r, st_nxt;
  logic cyc_on, rd_now, lin_rdy, cod_rdy;
  logic [5:0] lin_lvl, cod_lvl;
  logic [7:0] stat_byte;

  function automatic logic [7:0] read_mux(input logic [1:0] sel, input logic [7:0] msg,
                                          input logic [7:0] stat);
    case (sel)
      dsphp_pkg::ADDR_MSG: read_mux = msg;
      dsphp_pkg::ADDR_STAT: read_mux = stat;
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Style selects which strobe means what; second stage only is read
  always_comb begin
    if (SINGLE_STROBE_MODE) begin
      cyc_on = !st_r.cs_s[1] && !st_r.st_a_s[1];
      rd_now = st_r.dir_s[1];
    end else begin
      cyc_on = !st_r.cs_s[1] && (!st_r.st_a_s[1] || !st_r.st_b_s[1]);
      rd_now = !st_r.st_b_s[1];
    end
  end

  always_comb begin
    stat_byte = 8'h00;
    stat_byte[dsphp_pkg::BIT_OUT_VALID] = st_r.out_valid;
    stat_byte[dsphp_pkg::BIT_IN_PEND] = st_r.in_pend;
    stat_byte[dsphp_pkg::BIT_FULL_COD] = (cod_lvl >= dsphp_pkg::ALMOST_FULL);
    stat_byte[dsphp_pkg::BIT_FULL_LIN] = (lin_lvl >= dsphp_pkg::ALMOST_FULL);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[0], CHIP_SEL_N};
    st_nxt.st_a_s = {st_r.st_a_s[0], STROBE_A_N};
    st_nxt.st_b_s = {st_r.st_b_s[0], STROBE_B_N};
    st_nxt.dir_s = {st_r.dir_s[0], STROBE_B_N};
    st_nxt.a_s0 = {REG_SEL_HI, REG_SEL_LO};
    st_nxt.a_s1 = st_r.a_s0;
    st_nxt.d_s0 = DATA_IN;
    st_nxt.d_s1 = st_r.d_s0;
    st_nxt.lin_push = 1'b0;
    st_nxt.cod_push = 1'b0;
    st_nxt.active = cyc_on;
    if (cyc_on && !st_r.active) begin
      st_nxt.rd_cyc = rd_now;
      st_nxt.req.sel = st_r.a_s1;
    end
    // Data kept fresh while active so the last sample before release wins
    if (cyc_on) st_nxt.req.data = st_r.d_s1;
    if (cyc_on && st_nxt.rd_cyc) begin
      st_nxt.doe = (st_nxt.req.sel == dsphp_pkg::ADDR_MSG) ||
                   (st_nxt.req.sel == dsphp_pkg::ADDR_STAT);
      st_nxt.dout = read_mux(st_nxt.req.sel, st_r.msg_out, stat_byte);
    end else begin
      st_nxt.doe = 1'b0;
      st_nxt.dout = 8'h00;
    end
    // DSP side first so that a host set in the same cycle wins
    if (DSP_MSG_RD) st_nxt.in_pend = 1'b0;
    if (DSP_MSG_WR) begin
      st_nxt.msg_out = DSP_MSG_WDATA;
      st_nxt.out_valid = 1'b1;
    end
    if (!cyc_on && st_r.active) begin
      if (!st_r.rd_cyc) begin
        case (st_r.req.sel)
          dsphp_pkg::ADDR_MSG: begin
            st_nxt.msg_in = st_r.req.data;
            st_nxt.in_pend = 1'b1;
          end
          dsphp_pkg::ADDR_STAT: begin
            st_nxt.rst_lin = st_r.req.data[dsphp_pkg::BIT_RST_LIN];
            st_nxt.rst_cod = st_r.req.data[dsphp_pkg::BIT_RST_COD];
          end
          dsphp_pkg::ADDR_LIN: st_nxt.lin_push = lin_rdy;
          dsphp_pkg::ADDR_COD: st_nxt.cod_push = cod_rdy;
          default: ;
        endcase
        st_nxt.push_data = st_r.req.data;
      end else if (st_r.req.sel == dsphp_pkg::ADDR_MSG && !DSP_MSG_WR) begin
        st_nxt.out_valid = 1'b0;
      end
    end
    st_nxt.irq_n = !(NOTIFY_EN && st_nxt.out_valid);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      st_r <= '0;
      st_r.cs_s <= 2'h3;
      st_r.st_a_s <= 2'h3;
      st_r.st_b_s <= 2'h3;
      st_r.irq_n <= 1'b1;
      st_r.msg_in <= dsphp_pkg::MSG_RESET;
      st_r.msg_out <= dsphp_pkg::MSG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Full FIFO drops the byte; the almost-full flag warns host beforehand
  dsphp_fifo #(.W(dsphp_pkg::FIFO_W), .D(dsphp_pkg::FIFO_D)) u_lin (
    .clk(SYS_CLK), .rst(SYS_RST || st_r.rst_lin),
    .in_data(st_r.push_data), .in_valid(st_r.lin_push), .in_ready(lin_rdy),
    .out_data(LIN_DATA), .out_valid(LIN_VALID), .out_ready(LIN_READY), .level(lin_lvl));
  dsphp_fifo #(.W(dsphp_pkg::FIFO_W), .D(dsphp_pkg::FIFO_D)) u_cod (
    .clk(SYS_CLK), .rst(SYS_RST || st_r.rst_cod),
    .in_data(st_r.push_data), .in_valid(st_r.cod_push), .in_ready(cod_rdy),
    .out_data(COD_DATA), .out_valid(COD_VALID), .out_ready(COD_READY), .level(cod_lvl));

  assign DATA_OUT = st_r.dout;
  assign DATA_OE = st_r.doe;
  assign MESSAGE_PENDING_N = st_r.irq_n;
  assign DSP_MSG_RDATA = st_r.msg_in;
  assign DSP_IN_PEND = st_r.in_pend;
  assign DSP_OUT_VALID = st_r.out_valid;
  assign LIN_PORT_RST = st_r.rst_lin;
  assign COD_PORT_RST = st_r.rst_cod;

  a_irq_mirror: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    MESSAGE_PENDING_N == !(DSP_OUT_VALID && $past(NOTIFY_EN)))
    else $error("pending output disagrees with outbound flag");
  // Read data is one clock behind the flag, so compare with its past value
  a_stat_mirror: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (DATA_OE && st_r.req.sel == dsphp_pkg::ADDR_STAT) |->
    DATA_OUT[dsphp_pkg::BIT_OUT_VALID] == $past(DSP_OUT_VALID))
    else $error("status bit does not mirror outbound flag");
  a_dsp_sets: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    DSP_MSG_WR |=> DSP_OUT_VALID)
    else $error("dsp message write did not set outbound flag");
  a_host_sets: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (!cyc_on && st_r.active && !st_r.rd_cyc && st_r.req.sel == dsphp_pkg::ADDR_MSG)
    |=> DSP_IN_PEND)
    else $error("host message write did not set inbound flag");
  a_no_audio_read: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    DATA_OE |-> st_r.req.sel[1] == 1'b0)
    else $error("audio address driven on read");
  a_release_data: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !cyc_on |=> !DATA_OE)
    else $error("data pins held after read end");
  a_read_drive: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    (cyc_on && !st_r.active && rd_now && !st_r.a_s1[1]) |=> DATA_OE)
    else $error("read did not drive data");
  a_one_push: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_r.lin_push |=> !st_r.lin_push)
    else $error("audio byte pushed twice");
  a_push_cause: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    st_r.cod_push |-> $past(st_r.req.sel) == dsphp_pkg::ADDR_COD)
    else $error("coded push without coded write");
endmodule

// *** dv/dsphp_host.sv ***
// Purpose: Host side model driving the byte wide port pins
// Assumes: Pins change just after SYS_CLK edges
// Notes: Data pins show the inverted last byte once released
`timescale 1ns/1ps
module dsphp_host (
  input wire logic clk,
  input wire logic single,
  input wire logic [7:0] bus_q,
  input wire logic bus_oe,
  output logic cs_n,
  output logic sa_n,
  output logic sb_n,
  output logic [1:0] sel,
  output logic [7:0] wd
);
  initial begin
    cs_n = 1'b1;
    sa_n = 1'b1;
    sb_n = 1'b1;
    sel = 2'h0;
    wd = 8'h00;
  end
  // Strobes held 6 clocks, idle 6: covers the 2 flop synchronisers
  task automatic xfer(input logic rd, input logic [1:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe);
    @(posedge clk);
    sel <= a;
    if (single) sb_n <= rd;
    @(posedge clk);
    cs_n <= 1'b0;
    if (single || !rd) sa_n <= 1'b0;
    else sb_n <= 1'b0;
    @(posedge clk);
    if (!rd) wd <= d;
    repeat (5) @(posedge clk);
    q = bus_q;
    oe = bus_oe;
    cs_n <= 1'b1;
    sa_n <= 1'b1;
    if (!single) sb_n <= 1'b1;
    repeat (3) @(posedge clk);
    wd <= ~wd;
    repeat (3) @(posedge clk);
  endtask
endmodule

// *** dv/dsphp_port_test.sv ***
// Purpose: Self checking bench for the dual style host port
// Assumes: 20 MHz clock, host cycles from dsphp_host
// Notes: Both strobe styles run the same message sequence
`timescale 1ns/1ps
module dsphp_port_test;
  logic clk, rst, mode, notify, dwr, drd, lrdy, crdy, cs_n, sa_n, sb_n, oe, doe, pend_n;
  logic in_pend, out_val, lval, cval, lrst, crst;
  logic [1:0] sel;
  logic [7:0] dwd, q, hwd, dout, din, drdat, ldat, cdat;
  int bad_count, checks;
  assign din = doe ? dout : hwd;
  dsphp_host host_u (.clk(clk), .single(mode), .bus_q(din), .bus_oe(doe), .cs_n(cs_n),
    .sa_n(sa_n), .sb_n(sb_n), .sel(sel), .wd(hwd));
  dsphp_port dut_u (.SYS_CLK(clk), .SYS_RST(rst), .SINGLE_STROBE_MODE(mode),
    .CHIP_SEL_N(cs_n), .STROBE_A_N(sa_n), .STROBE_B_N(sb_n), .REG_SEL_HI(sel[1]),
    .REG_SEL_LO(sel[0]), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe),
    .MESSAGE_PENDING_N(pend_n), .NOTIFY_EN(notify), .DSP_MSG_WR(dwr),
    .DSP_MSG_WDATA(dwd), .DSP_MSG_RD(drd), .DSP_MSG_RDATA(drdat), .DSP_IN_PEND(in_pend),
    .DSP_OUT_VALID(out_val), .LIN_DATA(ldat), .LIN_VALID(lval), .LIN_READY(lrdy),
    .COD_DATA(cdat), .COD_VALID(cval), .COD_READY(crdy), .LIN_PORT_RST(lrst),
    .COD_PORT_RST(crst));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic hw(input logic [1:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, q, oe);
  endtask
  task automatic hr(input logic [1:0] a);
    host_u.xfer(1'b1, a, 8'h00, q, oe);
  endtask
  // One cycle DSP side pulse, then one edge to let flags land
  task automatic dsp(input logic w, input logic [7:0] d);
    @(posedge clk);
    dwr <= w;
    drd <= !w;
    dwd <= d;
    @(posedge clk);
    dwr <= 1'b0;
    drd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
  initial begin
    {rst, mode, notify, dwr, drd, lrdy, crdy, dwd} = {7'h40, 8'h00};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("pend_rst", 8'h01, {7'h0, pend_n});
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      notify <= m[0];
      repeat (2) @(posedge clk);
      hr(dsphp_pkg::ADDR_STAT);
      chk("stat_oe", 8'h01, {7'h0, oe});
      chk("stat0", 8'h00, q);
      hw(dsphp_pkg::ADDR_MSG, 8'ha5 + m[7:0]);
      chk("in_pend", 8'h01, {7'h0, in_pend});
      chk("msg_in", 8'ha5 + m[7:0], drdat);
      hr(dsphp_pkg::ADDR_STAT);
      chk("stat_in", 8'h04, q);
      dsp(1'b0, 8'h00);
      chk("in_clr", 8'h00, {7'h0, in_pend});
      dsp(1'b1, 8'h3c ^ m[7:0]);
      chk("pend_n", {7'h0, !m[0]}, {7'h0, pend_n});
      hr(dsphp_pkg::ADDR_STAT);
      chk("stat_out", 8'h02, q);
      hr(dsphp_pkg::ADDR_MSG);
      chk("msg_out", 8'h3c ^ m[7:0], q);
      chk("out_clr", 8'h02, {6'h0, pend_n, out_val});
      chk("oe_off", 8'h00, {7'h0, doe});
      hr(dsphp_pkg::ADDR_LIN);
      chk("oe_lin", 8'h00, {7'h0, oe});
      hr(dsphp_pkg::ADDR_COD);
      chk("oe_cod", 8'h00, {7'h0, oe});
      $display("test style %0d done", m);
    end
    hw(dsphp_pkg::ADDR_COD, 8'h5a);
    chk("cod", 8'h5a, cdat);
    chk("cod_v", 8'h01, {7'h0, cval});
    // 33 writes: the last must be dropped, FIFO holds 32
    for (int i = 0; i < 33; i++) hw(dsphp_pkg::ADDR_LIN, i[7:0]);
    hr(dsphp_pkg::ADDR_STAT);
    chk("stat_full", 8'h10, q);
    lrdy <= 1'b1;
    crdy <= 1'b1;
    // Sampled at the falling edge, where the FIFO outputs have settled
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      chk("lin", i[7:0], ldat);
      chk("lin_v", 8'h01, {7'h0, lval});
    end
    @(negedge clk);
    chk("lin_empty", 8'h00, {6'h0, lval, cval});
    hw(dsphp_pkg::ADDR_STAT, 8'h60);
    chk("port_rst", 8'h03, {6'h0, crst, lrst});
    hw(dsphp_pkg::ADDR_STAT, 8'h00);
    chk("port_run", 8'h00, {6'h0, crst, lrst});
    $display("test audio fifo done");
    give_verdict;
  end
endmodule
